/* hdl/msf_pkg.sv */
// Package holding the register map, field layout and sizes of the score front end.
package msf_pkg;
  // Index addresses of the serial write port.
  localparam logic [7:0] IDX_SCORE = 8'h00;
  localparam logic [7:0] IDX_VOICE_LO = 8'h10;
  localparam logic [7:0] IDX_VOICE_HI = 8'h2F;
  localparam logic [7:0] IDX_ALLOT = 8'h30;
  localparam logic [7:0] IDX_TEMPO = 8'h31;
  localparam logic [7:0] IDX_SEQ_CTRL = 8'h32;
  localparam logic [7:0] IDX_IRQ_CTRL = 8'h34;
  localparam logic [7:0] IDX_POWER = 8'h38;
  // Frame layout: 8-bit index then 16-bit data, MSB first.
  localparam int FRAME_BITS = 24;
  localparam int DATA_BITS = 16;
  // Control field positions.
  localparam int SEQ_START_BIT = 0;
  localparam int SEQ_CLEAR_BIT = 1;
  localparam int IRQ_ENABLE_BIT = 5;
  localparam int IRQ_POINT_MSB = 4;
  localparam int POWER_DIGITAL_BIT = 0;
  // Score word fields.
  localparam int NOTE_MSB = 13;
  localparam int NOTE_LSB = 10;
  localparam logic [3:0] REST_NOTE_CODE = 4'hC;
  localparam logic [1:0] REST_BLOCK_CODE = 2'h0;
  localparam int CHAN_MSB = 9;
  localparam int CHAN_LSB = 8;
  localparam int LEN_MSB = 6;
  localparam int LEN_LSB = 3;
  // Sizes.
  localparam int QUEUE_DEPTH = 32;
  localparam int VOICE_WORDS = 32;
  localparam int VOICE_COUNT = 8;
  localparam int CHANNELS = 4;
  // Reset values.
  localparam logic [7:0] TEMPO_RESET = 8'h00;
  localparam logic [4:0] IRQ_POINT_RESET = 5'h00;
  localparam logic [15:0] VOICE_RESET = 16'h0000;
  // Tempo tick divider: one tick every TEMPO_UNIT_CYCLES per tempo step.
  localparam int TEMPO_UNIT_NS = 1000;
  localparam int CLK_PERIOD_NS = 5;
  localparam int TEMPO_UNIT_CYCLES = TEMPO_UNIT_NS / CLK_PERIOD_NS;
endpackage : msf_pkg

/* hdl/msf_fifo.sv */
// Synchronous flip-flop FIFO with valid/ready on both sides.
`timescale 1ns/10ps
module msf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 8
) (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  input wire logic flush,
  // Fill side.
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  // Drain side.
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data,
  // Fill level.
  output logic [$clog2(DEPTH+1)-1:0] level
);
  localparam int AW = $clog2(DEPTH);
  localparam int LW = $clog2(DEPTH+1);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] rd;
    logic [AW-1:0] wr;
    logic [LW-1:0] cnt;
  } msf_fifo_state_t;

  msf_fifo_state_t st;
  msf_fifo_state_t next_st;
  logic push;
  logic pop;

  // Full and empty come straight from the count, so they are always honest.
  always_comb begin
    in_ready = (st.cnt != LW'(DEPTH));
    out_valid = (st.cnt != '0);
    out_data = st.mem[st.rd];
    level = st.cnt;
    push = in_valid && in_ready;
    pop = out_valid && out_ready;
    next_st = st;
    if (push) begin
      next_st.mem[st.wr] = in_data;
      next_st.wr = (st.wr == AW'(DEPTH - 1)) ? '0 : st.wr + 1'b1;
    end
    if (pop) begin
      next_st.rd = (st.rd == AW'(DEPTH - 1)) ? '0 : st.rd + 1'b1;
    end
    next_st.cnt = st.cnt + LW'(push) - LW'(pop);
    if (flush) begin
      next_st.rd = '0;
      next_st.wr = '0;
      next_st.cnt = '0;
    end
  end

  // State register.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end
endmodule : msf_fifo

/* hdl/msf_frontend.sv */
// Score front end: serial write port, score queue, sequencer, voice store.
`timescale 1ns/10ps
module msf_frontend #(
  parameter int QDEPTH = msf_pkg::QUEUE_DEPTH,
  parameter int STAGE_DEPTH = 8
) (
  // Clock and hardware reset.
  input wire logic clk,
  input wire logic rstn,
  // Serial write port from the host.
  input wire logic serial_sync,
  input wire logic serial_bit_clock,
  input wire logic serial_write_data_in,
  // Interrupt to the host, active low.
  output logic irq_n,
  // Voice generation controls, one slot per channel, then the single run and power-down flags.
  output logic [msf_pkg::CHANNELS-1:0] key_on,
  output logic [msf_pkg::CHANNELS-1:0][3:0] note_code,
  output logic [msf_pkg::CHANNELS-1:0][1:0] octave_block,
  output logic [msf_pkg::CHANNELS-1:0][15:0] voice_word,
  output logic seq_running,
  output logic digital_powered_down
);
  localparam int LW = $clog2(QDEPTH+1);
  localparam int SW = $clog2(STAGE_DEPTH+1);
  localparam int TCW = $clog2(msf_pkg::TEMPO_UNIT_CYCLES+1);

  typedef struct packed {
    logic [2:0] sync_sh;
    logic [2:0] sclk_sh;
    logic [2:0] serial_write_data_in_sh;
    logic sclk_prev;
    logic [4:0] bit_cnt;
    logic [msf_pkg::FRAME_BITS-1:0] shreg;
    logic [msf_pkg::FRAME_BITS-1:0] frame;
    logic frame_valid;
  } msf_rx_t;

  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_FETCH = 2'b01,
    SEQ_HOLD = 2'b10
  } msf_seq_state_t;

  typedef struct packed {
    logic [msf_pkg::VOICE_WORDS-1:0][15:0] voice;
    logic [15:0] allot;
    logic [7:0] tempo;
    logic run;
    logic irq_en;
    logic [4:0] irq_point;
    logic pdown;
    msf_seq_state_t seq;
    logic [TCW-1:0] unit_cnt;
    logic [7:0] step_cnt;
    logic [3:0] len_cnt;
    logic irq_n;
    logic [msf_pkg::CHANNELS-1:0] key_on;
    logic [msf_pkg::CHANNELS-1:0][3:0] note_code;
    logic [msf_pkg::CHANNELS-1:0][1:0] octave_block;
  } msf_core_t;

  msf_rx_t rx;
  msf_rx_t next_rx;
  msf_core_t cs;
  msf_core_t next_cs;

  logic [7:0] w_index;
  logic [15:0] w_data;
  logic stage_in_valid;
  logic stage_in_ready;
  logic stage_out_valid;
  logic stage_out_ready;
  logic [15:0] stage_out_data;
  logic q_in_ready;
  logic q_out_valid;
  logic q_out_ready;
  logic [15:0] q_out_data;
  logic [LW-1:0] q_level;
  logic [SW-1:0] stage_level;
  logic soft_clear;
  logic tick;
  logic [1:0] ch;
  logic is_rest;

  // Serial receiver: three-stage samplers, edge found when stages 2 and 3
  // agree high after a settled low; a frame opens on sync and closes after 24 bits.
  always_comb begin
    next_rx = rx;
    next_rx.frame_valid = 1'b0;
    next_rx.sync_sh = {rx.sync_sh[1:0], serial_sync};
    next_rx.sclk_sh = {rx.sclk_sh[1:0], serial_bit_clock};
    next_rx.serial_write_data_in_sh = {rx.serial_write_data_in_sh[1:0], serial_write_data_in};
    if (rx.sclk_sh[2] == rx.sclk_sh[1]) begin
      next_rx.sclk_prev = rx.sclk_sh[2];
    end
    if (rx.sync_sh[2] && rx.sync_sh[1]) begin
      next_rx.bit_cnt = '0;
    end else if (rx.sclk_sh[2] && rx.sclk_sh[1] && !rx.sclk_prev) begin
      next_rx.shreg = {rx.shreg[msf_pkg::FRAME_BITS-2:0], rx.serial_write_data_in_sh[2]};
      if (rx.bit_cnt == 5'(msf_pkg::FRAME_BITS - 1)) begin
        next_rx.frame = {rx.shreg[msf_pkg::FRAME_BITS-2:0], rx.serial_write_data_in_sh[2]};
        next_rx.frame_valid = 1'b1;
        next_rx.bit_cnt = '0;
      end else begin
        next_rx.bit_cnt = rx.bit_cnt + 5'h01;
      end
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx <= '0;
    end else begin
      rx <= next_rx;
    end
  end

  assign w_index = rx.frame[msf_pkg::FRAME_BITS-1:msf_pkg::DATA_BITS];
  assign w_data = rx.frame[msf_pkg::DATA_BITS-1:0];
  // A score word that finds the staging buffer full is refused and dropped here.
  assign stage_in_valid = rx.frame_valid && (w_index == msf_pkg::IDX_SCORE);
  assign soft_clear = rx.frame_valid && (w_index == msf_pkg::IDX_SEQ_CTRL)
    && w_data[msf_pkg::SEQ_CLEAR_BIT];

  // Small staging buffer decouples the receiver from the score queue.
  msf_fifo #(.WIDTH(16), .DEPTH(STAGE_DEPTH)) u_stage (
    .clk(clk),
    .rstn(rstn),
    .flush(soft_clear),
    .in_valid(stage_in_valid),
    .in_ready(stage_in_ready),
    .in_data(w_data),
    .out_valid(stage_out_valid),
    .out_ready(stage_out_ready),
    .out_data(stage_out_data),
    .level(stage_level)
  );

  // Staged words only move while the score queue has room.
  assign stage_out_ready = q_in_ready;

  // The score queue itself, drained only by the sequencer.
  msf_fifo #(.WIDTH(16), .DEPTH(QDEPTH)) u_queue (
    .clk(clk),
    .rstn(rstn),
    .flush(soft_clear),
    .in_valid(stage_out_valid),
    .in_ready(q_in_ready),
    .in_data(stage_out_data),
    .out_valid(q_out_valid),
    .out_ready(q_out_ready),
    .out_data(q_out_data),
    .level(q_level)
  );

  assign ch = q_out_data[msf_pkg::CHAN_MSB:msf_pkg::CHAN_LSB];
  assign is_rest = (q_out_data[msf_pkg::NOTE_MSB:msf_pkg::NOTE_LSB]
    == msf_pkg::REST_NOTE_CODE)
    && (q_out_data[15:14] == msf_pkg::REST_BLOCK_CODE);
  assign tick = (cs.unit_cnt == TCW'(msf_pkg::TEMPO_UNIT_CYCLES - 1))
    && (cs.step_cnt >= cs.tempo);
  assign q_out_ready = (cs.seq == SEQ_FETCH) && q_out_valid;

  // Register writes, sequencer and interrupt. The voice store is only
  // touched by writes and by hardware reset, never by clear or power-down.
  always_comb begin
    next_cs = cs;
    if (rx.frame_valid) begin
      if (w_index >= msf_pkg::IDX_VOICE_LO
          && w_index <= msf_pkg::IDX_VOICE_HI) begin
        // Store word number counts from the first voice index, so voice n
        // starts at word 4n, where the channel readout looks for it.
        next_cs.voice[5'(w_index - msf_pkg::IDX_VOICE_LO)] = w_data;
      end
      case (w_index)
        msf_pkg::IDX_ALLOT: next_cs.allot = w_data;
        msf_pkg::IDX_TEMPO: next_cs.tempo = w_data[7:0];
        msf_pkg::IDX_SEQ_CTRL: begin
          next_cs.run = w_data[msf_pkg::SEQ_START_BIT];
        end
        msf_pkg::IDX_IRQ_CTRL: begin
          next_cs.irq_en = w_data[msf_pkg::IRQ_ENABLE_BIT];
          next_cs.irq_point = w_data[msf_pkg::IRQ_POINT_MSB:0];
        end
        msf_pkg::IDX_POWER: begin
          next_cs.pdown = w_data[msf_pkg::POWER_DIGITAL_BIT];
        end
        default: begin
        end
      endcase
    end
    // Soft clear stops playback and silences channels, except one keyed by a fetch in the same cycle, but keeps voices.
    if (soft_clear) begin
      next_cs.run = 1'b0;
      next_cs.key_on = '0;
    end
    // Tempo divider: tick period is (tempo+1) units.
    if (cs.seq == SEQ_HOLD) begin
      if (cs.unit_cnt == TCW'(msf_pkg::TEMPO_UNIT_CYCLES - 1)) begin
        next_cs.unit_cnt = '0;
        next_cs.step_cnt = tick ? 8'h00 : cs.step_cnt + 8'h01;
      end else begin
        next_cs.unit_cnt = cs.unit_cnt + TCW'(1);
      end
    end
    case (cs.seq)
      SEQ_IDLE: begin
        if (cs.run && !cs.pdown) begin
          next_cs.seq = SEQ_FETCH;
        end
      end
      SEQ_FETCH: begin
        if (!cs.run) begin
          next_cs.seq = SEQ_IDLE;
        end else if (q_out_valid) begin
          // Each channel keys its own note; the voice comes via allotment.
          next_cs.key_on[ch] = !is_rest;
          next_cs.note_code[ch] =
            q_out_data[msf_pkg::NOTE_MSB:msf_pkg::NOTE_LSB];
          next_cs.octave_block[ch] = q_out_data[15:14];
          next_cs.len_cnt = q_out_data[msf_pkg::LEN_MSB:msf_pkg::LEN_LSB];
          next_cs.unit_cnt = '0;
          next_cs.step_cnt = '0;
          next_cs.seq = SEQ_HOLD;
        end
      end
      SEQ_HOLD: begin
        if (!cs.run) begin
          next_cs.seq = SEQ_IDLE;
        end else if (tick) begin
          if (cs.len_cnt == 4'h0) begin
            next_cs.seq = SEQ_FETCH;
          end else begin
            next_cs.len_cnt = cs.len_cnt - 4'h1;
          end
        end
      end
      default: next_cs.seq = SEQ_IDLE;
    endcase
    if (soft_clear) begin
      next_cs.seq = SEQ_IDLE;
    end
    // Level-driven, so it stays low while the condition holds.
    next_cs.irq_n = !(cs.irq_en
      && (q_level <= LW'(cs.irq_point)));
  end

  // Core register; the voice store resets only here, by hardware reset.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cs <= '0;
      cs.seq <= SEQ_IDLE;
      cs.tempo <= msf_pkg::TEMPO_RESET;
      cs.irq_point <= msf_pkg::IRQ_POINT_RESET;
      cs.irq_n <= 1'b1;
    end else begin
      cs <= next_cs;
    end
  end

  // Outputs come straight from state flip-flops.
  assign irq_n = cs.irq_n;
  assign key_on = cs.key_on;
  assign note_code = cs.note_code;
  assign octave_block = cs.octave_block;
  assign seq_running = cs.run;
  assign digital_powered_down = cs.pdown;

  // Each channel presents the first word of its allotted voice.
  genvar gi;
  generate
    for (gi = 0; gi < msf_pkg::CHANNELS; gi++) begin : g_chan
      assign voice_word[gi] =
        cs.voice[{cs.allot[gi*4 +: 3], 2'b00}];
    end
  endgenerate
endmodule : msf_frontend

/* bench/msf_monitor.sv */
// Port checker for the score front end, bound to its top module.
`timescale 1ns/10ps
module msf_monitor (
  // Clock and reset.
  input wire logic clk,
  input wire logic rstn,
  // Serial write port.
  input wire logic serial_sync,
  input wire logic serial_bit_clock,
  input wire logic serial_write_data_in,
  // Design outputs.
  input wire logic irq_n,
  input wire logic [msf_pkg::CHANNELS-1:0] key_on,
  input wire logic [msf_pkg::CHANNELS-1:0][3:0] note_code,
  input wire logic [msf_pkg::CHANNELS-1:0][1:0] octave_block,
  input wire logic [msf_pkg::CHANNELS-1:0][15:0] voice_word,
  input wire logic seq_running,
  input wire logic digital_powered_down
);
  logic bclk_q;
  logic [4:0] quiet;
  logic [8:0] gap;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  // Cycles since a bit clock rise; writes can only land shortly after one.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      bclk_q <= 1'b0;
      quiet <= 5'h1F;
    end else begin
      bclk_q <= serial_bit_clock;
      if (serial_bit_clock && !bclk_q) begin
        quiet <= 5'h00;
      end else if (quiet != 5'h1F) begin
        quiet <= quiet + 5'h01;
      end
    end
  end
  // Cycles since the last note change, saturating so it never wraps.
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      gap <= 9'h1FF;
    end else if ($changed(note_code)) begin
      gap <= 9'h000;
    end else if (gap != 9'h1FF) begin
      gap <= gap + 9'h001;
    end
  end
  reset_vals_a: assert property ($rose(rstn) |-> irq_n && key_on == '0
    && voice_word == '0 && !seq_running) else $error("bad reset values");
  voice_quiet_a: assert property ($changed(voice_word) |-> quiet < 12)
    else $error("voice word moved without a write");
  run_quiet_a: assert property ($changed(seq_running) |-> quiet < 12)
    else $error("run state moved without a write");
  pd_quiet_a: assert property ($changed(digital_powered_down)
    |-> quiet < 12) else $error("power bit moved without a write");
  irq_rise_a: assert property ($rose(irq_n)
    |-> quiet < 14 || $past(seq_running)) else $error("irq released late");
  irq_fall_a: assert property ($fell(irq_n)
    |-> quiet < 14 || $past(seq_running, 3)) else $error("irq with no cause");
  key_start_a: assert property ((key_on & ~$past(key_on)) != '0
    |-> $past(seq_running)) else $error("key on while stopped");
  note_gap_a: assert property ($changed(note_code) |-> gap > 9'd197)
    else $error("notes fetched too close");
endmodule : msf_monitor

bind msf_frontend msf_monitor i_mon (.clk(clk), .rstn(rstn),
  .serial_sync(serial_sync), .serial_bit_clock(serial_bit_clock),
  .serial_write_data_in(serial_write_data_in), .irq_n(irq_n),
  .key_on(key_on), .note_code(note_code), .octave_block(octave_block),
  .voice_word(voice_word), .seq_running(seq_running),
  .digital_powered_down(digital_powered_down));

/* bench/msf_host.sv */
// Host model that drives frames into the serial write port.
`timescale 1ns/10ps
module msf_host (
  // Serial port towards the device.
  output logic serial_sync,
  output logic serial_bit_clock,
  output logic serial_write_data_in
);
  // The bit clock stands still low between frames.
  initial begin
    serial_sync = 1'b0;
    serial_bit_clock = 1'b0;
    serial_write_data_in = 1'b0;
  end
  // One frame: sync pulse, then index and data MSB first at 80 ns a bit.
  task automatic send(input logic [7:0] idx, input logic [15:0] d);
    logic [23:0] w;
    w = {idx, d};
    serial_sync = 1'b1;
    #20;
    serial_sync = 1'b0;
    #20;
    for (int i = 23; i >= 0; i--) begin
      serial_write_data_in = w[i];
      #40;
      serial_bit_clock = 1'b1;
      #40;
      serial_bit_clock = 1'b0;
    end
    // Data is not held after a frame, so show the inverse, never a stale bit.
    serial_write_data_in = ~serial_write_data_in;
    #40;
  endtask : send
endmodule : msf_host

/* bench/tb.sv */
// Self-checking bench for the score front end.
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic sync, sck, sdi, irq_n, run, pd;
  logic [3:0] key_on;
  logic [3:0][3:0] note_code;
  logic [3:0][1:0] octave_block;
  logic [3:0][15:0] voice_word;
  int error_cnt = 0;
  int num_checks = 0;
  int seed = 49;
  logic [2:0] v;
  logic [1:0] ch;
  logic [3:0] nt;
  logic [15:0] a, b;
  // Half period of the 200 MHz clock.
  always #2.5 clk = ~clk;
  msf_frontend i_dut (.clk(clk), .rstn(rstn), .serial_sync(sync),
    .serial_bit_clock(sck), .serial_write_data_in(sdi), .irq_n(irq_n),
    .key_on(key_on), .note_code(note_code), .octave_block(octave_block),
    .voice_word(voice_word), .seq_running(run),
    .digital_powered_down(pd));
  msf_host i_host (.serial_sync(sync), .serial_bit_clock(sck),
    .serial_write_data_in(sdi));
  // Compares one value and reports a mismatch at once.
  task automatic chk(input string n, input logic [15:0] e,
    input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // Only documented indexes are sent; waits past the 4-5 cycle landing.
  task automatic wr(input logic [7:0] i, input logic [15:0] d);
    i_host.send(i, d);
    repeat (10) @(posedge clk);
    #1;
  endtask : wr
  // Expected score word with a zero length field.
  function automatic logic [15:0] score(logic [1:0] bl, logic [3:0] n,
    logic [1:0] c);
    return {bl, n, c, 8'h00};
  endfunction : score
  // Channels 0 and 2 use voice v, channels 1 and 3 use voice 7.
  task automatic check_voices();
    for (int i = 0; i < 4; i++) begin
      chk("voice_word", i[0] ? b : a, voice_word[i]);
    end
  endtask : check_voices
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : tally_and_finish
  // Runaway guard, well past the longest expected run.
  initial begin
    #400000;
    error_cnt++;
    $display("CHECK FAILED watchdog expected done seen timeout");
    tally_and_finish();
  end
  initial begin
    repeat (8) @(posedge clk);
    #1 rstn = 1'b1;
    @(posedge clk);
    #1;
    chk("irq_n", 16'h0001, 16'(irq_n));
    chk("voice_word", 16'h0000, voice_word[0]);
    $display("test reset done");
    v = 3'($random(seed));
    if (v == 3'h7) v = 3'h6;
    a = 16'($random(seed));
    b = 16'($random(seed));
    wr(msf_pkg::IDX_VOICE_LO + 8'({v, 2'h0}), a);
    wr(8'h2C, b);
    wr(msf_pkg::IDX_ALLOT, {4'h7, 1'h0, v, 4'h7, 1'h0, v});
    check_voices();
    wr(msf_pkg::IDX_SEQ_CTRL, 16'h0002);
    check_voices();
    wr(msf_pkg::IDX_POWER, 16'h0001);
    chk("powered_down", 16'h0001, 16'(pd));
    wr(msf_pkg::IDX_POWER, 16'h0000);
    chk("powered_down", 16'h0000, 16'(pd));
    check_voices();
    $display("test voice store done");
    ch = 2'($random(seed));
    nt = 4'($random(seed)) % 4'hC;
    wr(msf_pkg::IDX_IRQ_CTRL, 16'h0022);
    chk("irq_n", 16'h0000, 16'(irq_n));
    wr(msf_pkg::IDX_SCORE, score(2'h1, nt, ch));
    wr(msf_pkg::IDX_SCORE, score(2'h2, nt, ch));
    wr(msf_pkg::IDX_SCORE, score(2'h0, 4'hC, ch));
    chk("irq_n", 16'h0001, 16'(irq_n));
    chk("key_on", 16'h0000, 16'(key_on));
    wr(msf_pkg::IDX_SEQ_CTRL, 16'h0001);
    chk("seq_running", 16'h0001, 16'(run));
    chk("key_on", 16'h0001, 16'(key_on[ch]));
    chk("note_code", 16'(nt), 16'(note_code[ch]));
    chk("octave", 16'h0001, 16'(octave_block[ch]));
    chk("irq_n", 16'h0000, 16'(irq_n));
    repeat (250) @(posedge clk);
    #1;
    chk("octave", 16'h0002, 16'(octave_block[ch]));
    repeat (300) @(posedge clk);
    #1;
    chk("key_on", 16'h0000, 16'(key_on[ch]));
    wr(msf_pkg::IDX_SEQ_CTRL, 16'h0000);
    chk("seq_running", 16'h0000, 16'(run));
    $display("test playback done");
    wr(msf_pkg::IDX_IRQ_CTRL, 16'h003F);
    for (int k = 0; k < 41; k++) begin
      wr(msf_pkg::IDX_SCORE, score(2'h1, 4'(k % 12), 2'h0));
      if (k == 30) chk("irq_n", 16'h0000, 16'(irq_n));
    end
    chk("irq_n", 16'h0001, 16'(irq_n));
    wr(msf_pkg::IDX_SEQ_CTRL, 16'h0002);
    chk("irq_n", 16'h0000, 16'(irq_n));
    chk("key_on", 16'h0000, 16'(key_on));
    check_voices();
    $display("test overflow done");
    tally_and_finish();
  end
endmodule : tb
